// File: spu_core_model.sv
// Core model that issues stack operations to the unit
`timescale 1ns/1ps
module spu_core_model (
    // Request from bench
    input wire spu_pkg::spu_op_type req_i,
    // Operation to unit
    output spu_pkg::spu_op_type op_o
);
    // Ops follow the request unchanged; calls pass through whether or not the stack is set
    assign op_o = req_i;
endmodule : spu_core_model

// File: spu_pkg.sv
// Package with constants for the stack pointer unit
// How it works
// [R01] The stack grows downward, so storing onto it lowers the pointer.
// [R02] The pointer always addresses the current top of the stack in data SRAM.
// [R03] A single byte push lowers the pointer by one.
// [R04] A call or interrupt entry storing a return address lowers the pointer by two.
// [R05] A single byte pop raises the pointer by one.
// [R06] A subroutine or interrupt return raises the pointer by two.
// [R07] Reset loads the pointer with the last SRAM address.
// [R08] The pointer is read and written as two byte registers, high at 0x3E and low at 0x3D.
// [R09] When the data space fits the low byte, the high byte register is absent.
// [R10] Software sets a valid stack area before any call or enabling interrupts.
// [R11] A push writes at the current address then decrements; a pop increments then reads.
package spu_pkg;
    // ========================================
    // Register map
    localparam logic [5:0] SPU_ADDR_LOW = 6'h3D;
    localparam logic [5:0] SPU_ADDR_HIGH = 6'h3E;
    // ========================================
    // Reset value and steps
    localparam logic [15:0] SPU_LAST_SRAM_ADDRESS = 16'h08FF;
    localparam logic [15:0] SPU_STEP_BYTE = 16'h0001;
    localparam logic [15:0] SPU_STEP_ADDR = 16'h0002;
    // ========================================
    // Stack operations
    typedef enum logic [2:0] {
        SPU_OP_NONE = 3'b000,
        SPU_OP_PUSH = 3'b001,
        SPU_OP_CALL = 3'b010,
        SPU_OP_POP = 3'b011,
        SPU_OP_RET = 3'b100
    } spu_op_type;
endpackage : spu_pkg

// File: spu_stack_pointer.sv
// Stack pointer unit with its two I/O byte registers
`timescale 1ns/1ps
module spu_stack_pointer #(
    parameter bit HAS_HIGH = 1'b1,
    parameter logic [15:0] LAST_SRAM = spu_pkg::SPU_LAST_SRAM_ADDRESS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Core stack operation
    input wire spu_pkg::spu_op_type op_i,
    output logic [15:0] sp_o,
    output logic [15:0] mem_addr_o,
    // I/O register access
    input wire logic [5:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_hit_o
);
    logic [15:0] sp_ff;
    logic [15:0] nxt_sp;
    logic [15:0] step_addr;
    logic wr_low;
    logic wr_high;

    // ========================================
    // Arithmetic
    spu_step #(.WIDTH(16)) u_step (
        .cur_i(sp_ff),
        .op_i(op_i),
        .nxt_o(nxt_sp),
        .mem_addr_o(step_addr)
    );

    // Register decode
    assign wr_low = io_wr_i && (io_addr_i == spu_pkg::SPU_ADDR_LOW); // [R08]
    assign wr_high = io_wr_i && HAS_HIGH && (io_addr_i == spu_pkg::SPU_ADDR_HIGH); // [R08] [R09]

    // ========================================
    // Pointer register; core operation wins over software write in same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sp_ff <= LAST_SRAM; // [R07]
        end else if (op_i != spu_pkg::SPU_OP_NONE) begin
            sp_ff <= nxt_sp; // [R02]
        end else begin
            if (wr_low) begin
                sp_ff[7:0] <= io_wdata_i; // [R08]
            end
            if (wr_high) begin
                sp_ff[15:8] <= io_wdata_i; // [R08]
            end
        end
    end

    // ========================================
    // Outputs
    assign sp_o = HAS_HIGH ? sp_ff : {8'h00, sp_ff[7:0]}; // [R09]
    assign mem_addr_o = HAS_HIGH ? step_addr : {8'h00, step_addr[7:0]}; // [R11]

    // Read data
    always_comb begin
        io_rdata_o = 8'h00;
        io_hit_o = 1'b0;
        if (io_addr_i == spu_pkg::SPU_ADDR_LOW) begin
            io_rdata_o = sp_ff[7:0]; // [R08]
            io_hit_o = 1'b1;
        end else if (HAS_HIGH && io_addr_i == spu_pkg::SPU_ADDR_HIGH) begin
            io_rdata_o = sp_ff[15:8]; // [R08] [R09]
            io_hit_o = 1'b1;
        end
    end

    // ========================================
    // Checks
    sequence s_push;
        op_i == spu_pkg::SPU_OP_PUSH;
    endsequence
    sequence s_call;
        op_i == spu_pkg::SPU_OP_CALL;
    endsequence

    a_push_dec: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R03]
        s_push |=> sp_ff == $past(sp_ff) - 16'h0001)
        else $error("push did not lower pointer by one");
    a_call_dec: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R04]
        s_call |=> sp_ff == $past(sp_ff) - 16'h0002)
        else $error("call did not lower pointer by two");
    a_pop_inc: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R05]
        op_i == spu_pkg::SPU_OP_POP |=> sp_ff == $past(sp_ff) + 16'h0001)
        else $error("pop did not raise pointer by one");
    a_ret_inc: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06]
        op_i == spu_pkg::SPU_OP_RET |=> sp_ff == $past(sp_ff) + 16'h0002)
        else $error("return did not raise pointer by two");
    a_push_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        s_push |-> step_addr == sp_ff)
        else $error("push address is not current pointer");
    a_pop_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        op_i == spu_pkg::SPU_OP_POP |-> step_addr == sp_ff + 16'h0001)
        else $error("pop address is not incremented pointer");
    a_push_down: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R01]
        (s_push or s_call) ##1 op_i == spu_pkg::SPU_OP_NONE |-> sp_ff < $past(sp_ff)
            || $past(sp_ff) < 16'h0002)
        else $error("stack did not grow downward");
    a_low_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R08]
        wr_low && op_i == spu_pkg::SPU_OP_NONE |=> sp_ff[7:0] == $past(io_wdata_i))
        else $error("low byte write lost");
    a_idle_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R02]
        op_i == spu_pkg::SPU_OP_NONE && !io_wr_i |=> $stable(sp_ff))
        else $error("pointer moved without cause");
    a_high_absent: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R09]
        !HAS_HIGH && io_addr_i == spu_pkg::SPU_ADDR_HIGH |-> !io_hit_o)
        else $error("absent high byte answered");

    // ========================================
    // Operation and write sequences
    sequence s_pop;
        op_i == spu_pkg::SPU_OP_POP;
    endsequence
    sequence s_ret;
        op_i == spu_pkg::SPU_OP_RET;
    endsequence
    sequence s_idle;
        op_i == spu_pkg::SPU_OP_NONE;
    endsequence
    sequence s_any_op;
        op_i != spu_pkg::SPU_OP_NONE;
    endsequence
    sequence s_low_wr;
        wr_low && op_i == spu_pkg::SPU_OP_NONE;
    endsequence
    sequence s_high_wr;
        wr_high && op_i == spu_pkg::SPU_OP_NONE;
    endsequence

    // ========================================
    // Access address for calls, returns and idle cycles
    // A call stores at the current top; a return reads one above it
    a_call_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R04] [R11]
        s_call |-> step_addr == sp_ff)
        else $error("call address is not current pointer");
    a_ret_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06] [R11]
        s_ret |-> step_addr == sp_ff + spu_pkg::SPU_STEP_BYTE)
        else $error("return address is not incremented pointer");
    a_idle_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R02]
        s_idle |-> step_addr == sp_ff)
        else $error("idle address is not current pointer");

    // ========================================
    // Where the pointer ends after each operation
    // Ties the moved pointer to the address used in the same cycle
    a_push_end: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        s_push |=> sp_ff == $past(step_addr) - spu_pkg::SPU_STEP_BYTE)
        else $error("push did not end below written byte");
    a_call_end: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R04] [R11]
        s_call |=> sp_ff == $past(step_addr) - spu_pkg::SPU_STEP_ADDR)
        else $error("call did not end below return address");
    a_pop_end: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R11]
        s_pop |=> sp_ff == $past(step_addr))
        else $error("pop did not end at read byte");
    a_ret_second: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R06] [R11]
        s_ret |=> sp_ff == $past(step_addr) + spu_pkg::SPU_STEP_BYTE)
        else $error("return did not end at second byte");

    // ========================================
    // Direction of growth on the way back
    // Wrap above the top of the 16-bit space is excused
    a_pop_up: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R01]
        (s_pop or s_ret) ##1 s_idle |-> sp_ff > $past(sp_ff)
            || $past(sp_ff) > 16'hFFFD)
        else $error("stack did not shrink upward");

    // ========================================
    // Software writes
    // Each byte lands alone; a core operation beats a write
    a_high_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R08]
        s_high_wr |=> sp_ff[15:8] == $past(io_wdata_i))
        else $error("high byte write lost");
    a_low_keeps_high: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R08]
        s_low_wr |=> sp_ff[15:8] == $past(sp_ff[15:8]))
        else $error("low byte write disturbed high byte");
    a_high_keeps_low: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R08]
        s_high_wr |=> sp_ff[7:0] == $past(sp_ff[7:0]))
        else $error("high byte write disturbed low byte");
    a_op_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R02]
        s_any_op ##0 io_wr_i |=> sp_ff == $past(nxt_sp))
        else $error("write overrode a stack operation");
    a_stray_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R08]
        s_idle ##0 (io_wr_i && !wr_low && !wr_high) |=> $stable(sp_ff))
        else $error("unmapped write moved pointer");

    // ========================================
    // Reset value
    // Checked while reset is held, so no disable here
    a_reset_value: assert property (@(posedge clk_i) // [R07]
        !rst_n_i |-> sp_ff == LAST_SRAM)
        else $error("reset did not load last SRAM address");

    // ========================================
    // Read side and the absent high byte
    // Unmapped addresses read as zero so stray reads are harmless
    a_read_low: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R08]
        io_addr_i == spu_pkg::SPU_ADDR_LOW |-> io_hit_o && io_rdata_o == sp_ff[7:0])
        else $error("low byte read wrong");
    a_read_high: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R08]
        HAS_HIGH && io_addr_i == spu_pkg::SPU_ADDR_HIGH |-> io_hit_o && io_rdata_o == sp_ff[15:8])
        else $error("high byte read wrong");
    a_read_stray: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R08]
        !io_hit_o |-> io_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_high_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R09]
        !HAS_HIGH |-> sp_o[15:8] == 8'h00 && mem_addr_o[15:8] == 8'h00)
        else $error("absent high byte shows bits");
    a_high_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R09]
        !HAS_HIGH && io_wr_i && op_i == spu_pkg::SPU_OP_NONE
            && io_addr_i == spu_pkg::SPU_ADDR_HIGH |=> $stable(sp_o))
        else $error("absent high byte took a write");

    // ========================================
    // Operation pairs that undo each other
    // Push then pop, and call then return, restore the pointer
    a_push_pop: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R03] [R05]
        s_push ##1 s_pop |=> sp_ff == $past(sp_ff, 2))
        else $error("push then pop did not restore pointer");
    a_call_ret: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R04] [R06]
        s_call ##1 s_ret |=> sp_ff == $past(sp_ff, 2))
        else $error("call then return did not restore pointer");
endmodule : spu_stack_pointer

// File: spu_step.sv
// Pointer arithmetic for one stack operation
`timescale 1ns/1ps
module spu_step #(
    parameter int WIDTH = 16
) (
    // Operation in
    input wire logic [WIDTH-1:0] cur_i,
    input wire spu_pkg::spu_op_type op_i,
    // Results
    output logic [WIDTH-1:0] nxt_o,
    output logic [WIDTH-1:0] mem_addr_o
);
    // ========================================
    // Next pointer and access address
    always_comb begin
        nxt_o = cur_i;
        mem_addr_o = cur_i;
        case (op_i)
            spu_pkg::SPU_OP_PUSH: begin
                nxt_o = cur_i - spu_pkg::SPU_STEP_BYTE[WIDTH-1:0]; // [R03] [R01]
            end
            spu_pkg::SPU_OP_CALL: begin
                nxt_o = cur_i - spu_pkg::SPU_STEP_ADDR[WIDTH-1:0]; // [R04]
            end
            spu_pkg::SPU_OP_POP: begin
                nxt_o = cur_i + spu_pkg::SPU_STEP_BYTE[WIDTH-1:0]; // [R05]
                mem_addr_o = nxt_o; // [R11]
            end
            spu_pkg::SPU_OP_RET: begin
                nxt_o = cur_i + spu_pkg::SPU_STEP_ADDR[WIDTH-1:0]; // [R06]
                mem_addr_o = cur_i + spu_pkg::SPU_STEP_BYTE[WIDTH-1:0]; // [R11]
            end
            default: begin
                nxt_o = cur_i;
            end
        endcase
    end
endmodule : spu_step

// File: tb.sv
// Self-checking testbench for the stack pointer unit
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0, rst_n_i = 1'b1, io_wr_i = 1'b0;
    logic [5:0] io_addr_i = 6'h00;
    logic [7:0] io_wdata_i = 8'h00, io_rdata_o;
    logic [15:0] sp_o, mem_addr_o, exp_sp, exp_addr, sp_b, mem_addr_b;
    logic [7:0] io_rdata_b;
    logic [31:0] rnd;
    logic io_hit_o, io_hit_b;
    spu_pkg::spu_op_type req = spu_pkg::SPU_OP_NONE, op;
    int error_cnt = 0, checks = 0, seed = 7919, cyc = 0;
    spu_core_model u_core (.req_i(req), .op_o(op));
    spu_stack_pointer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_i(op), .sp_o(sp_o),
        .mem_addr_o(mem_addr_o), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_hit_o(io_hit_o));
    // Second unit without the high byte register
    spu_stack_pointer #(.HAS_HIGH(1'b0)) u_dut_low (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .op_i(op), .sp_o(sp_b), .mem_addr_o(mem_addr_b), .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_b),
        .io_hit_o(io_hit_b));
    // ==========
    // Clock and timeout
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 5000) begin
            error_cnt++;
            close_out();
        end
    end
    // ==========
    // Helpers
    function logic [15:0] nxt_sp(input logic [15:0] s, input spu_pkg::spu_op_type o);
        case (o)
            spu_pkg::SPU_OP_PUSH: return s - 16'h0001;
            spu_pkg::SPU_OP_CALL: return s - 16'h0002;
            spu_pkg::SPU_OP_POP: return s + 16'h0001;
            spu_pkg::SPU_OP_RET: return s + 16'h0002;
            default: return s;
        endcase
    endfunction : nxt_sp
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // One cycle with an op and an optional write
    task cyc_do(input spu_pkg::spu_op_type o, input logic w, input logic [5:0] a,
                input logic [7:0] d);
        @(negedge clk_i);
        req = o;
        io_wr_i = w;
        io_addr_i = a;
        io_wdata_i = d;
        #1;
        exp_addr = exp_sp;
        if (o == spu_pkg::SPU_OP_POP || o == spu_pkg::SPU_OP_RET) exp_addr = exp_sp + 16'h0001;
        chk(mem_addr_o, exp_addr, "addr");
        chk(mem_addr_b, {8'h00, exp_addr[7:0]}, "addr_low");
        if (o != spu_pkg::SPU_OP_NONE) exp_sp = nxt_sp(exp_sp, o);
        else if (w && a == spu_pkg::SPU_ADDR_LOW) exp_sp[7:0] = d;
        else if (w && a == spu_pkg::SPU_ADDR_HIGH) exp_sp[15:8] = d;
        @(posedge clk_i);
        #1;
        io_wr_i = 1'b0;
        chk(sp_o, exp_sp, "sp");
        chk(sp_b, {8'h00, exp_sp[7:0]}, "sp_low");
    endtask : cyc_do
    // ==========
    // Main sequence
    initial begin
        exp_sp = spu_pkg::SPU_LAST_SRAM_ADDRESS;
        #1 rst_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        chk(sp_o, exp_sp, "reset");
        chk(sp_b, {8'h00, exp_sp[7:0]}, "reset_low");
        io_addr_i = spu_pkg::SPU_ADDR_HIGH;
        #1 chk({7'h00, io_hit_o, io_rdata_o}, {8'h01, exp_sp[15:8]}, "high");
        chk({7'h00, io_hit_b, io_rdata_b}, 16'h0000, "high_absent");
        io_addr_i = 6'h3F;
        #1 chk({7'h00, io_hit_o, io_rdata_o}, 16'h0000, "unmapped");
        cyc_do(spu_pkg::SPU_OP_NONE, 1'b1, spu_pkg::SPU_ADDR_LOW, 8'h00);
        cyc_do(spu_pkg::SPU_OP_NONE, 1'b1, spu_pkg::SPU_ADDR_HIGH, 8'h00);
        cyc_do(spu_pkg::SPU_OP_PUSH, 1'b1, spu_pkg::SPU_ADDR_LOW, 8'h55);
        cyc_do(spu_pkg::SPU_OP_NONE, 1'b1, 6'h3C, 8'hAA);
        io_addr_i = spu_pkg::SPU_ADDR_LOW;
        #1 chk({7'h00, io_hit_o, io_rdata_o}, {8'h01, exp_sp[7:0]}, "low");
        chk({7'h00, io_hit_b, io_rdata_b}, {8'h01, exp_sp[7:0]}, "low_only");
        cyc_do(spu_pkg::SPU_OP_NONE, 1'b1, spu_pkg::SPU_ADDR_HIGH, 8'h08);
        // Random operations with random writes around the register pair
        for (int i = 0; i < 300; i++) begin
            rnd = $random(seed);
            cyc_do(spu_pkg::spu_op_type'(3'(rnd % 5)), rnd[8],
                6'h3C + 6'(rnd[5:4]), rnd[23:16]);
        end
        // Reset in mid-run, then a call and a return
        @(negedge clk_i);
        req = spu_pkg::SPU_OP_NONE;
        rst_n_i = 1'b0;
        exp_sp = spu_pkg::SPU_LAST_SRAM_ADDRESS;
        #1 chk(sp_o, exp_sp, "reset_mid");
        @(negedge clk_i);
        rst_n_i = 1'b1;
        cyc_do(spu_pkg::SPU_OP_CALL, 1'b0, 6'h00, 8'h00);
        cyc_do(spu_pkg::SPU_OP_RET, 1'b0, 6'h00, 8'h00);
        close_out();
    end
endmodule : tb
